// >>> irrpu_pkg.sv
package irrpu_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam logic [1:0] ADR_CFG = 2'h0;
  localparam logic [1:0] ADR_CAR = 2'h1;
  localparam logic [1:0] ADR_LCNT = 2'h2;
  localparam logic [1:0] ADR_INT = 2'h3;
  localparam int CFG_RUN_BIT = 0;
  localparam int CFG_DIR_BIT = 1;
  localparam int CFG_LCSEL_LSB = 8;
  localparam int CFG_CGSEL_LSB = 12;
  localparam int CAR_HIGH_LSB = 0;
  localparam int CAR_LOW_LSB = 8;
  localparam int LCNT_VAL_LSB = 0;
  localparam int LCNT_LEVEL_BIT = 8;
  localparam int INT_UF_FLAG_BIT = 0;
  localparam int INT_RISE_FLAG_BIT = 1;
  localparam int INT_FALL_FLAG_BIT = 2;
  localparam int INT_UF_EN_BIT = 8;
  localparam int INT_RISE_EN_BIT = 9;
  localparam int INT_FALL_EN_BIT = 10;
  localparam logic [3:0] DIV_SEL_RESERVED = 4'h0_f;
  localparam logic [3:0] DIV_SEL_RESET = 4'h0_0;
  localparam logic [5:0] CAR_LEN_RESET = 6'h0_0;
  localparam logic [7:0] LEN_RESET = 8'h0_0;
  localparam logic [13:0] PRESCALE_RESET = 14'h0_000;

  typedef struct packed {
    logic [3:0] cg_sel;
    logic [3:0] lc_sel;
    logic dir_rx;
    logic run;
  } irrpu_cfg_t;

  typedef struct packed {
    logic uf;
    logic rise;
    logic fall;
  } irrpu_evt_t;
endpackage

// >>> irrpu_div_tick.sv
`timescale 1ns/1ps
// Produces a one-cycle tick every 2**sel input clocks off a shared prescaler; sel 15 is reserved and never ticks.
module irrpu_div_tick
  import irrpu_pkg::*;
(
  input wire logic [13:0] prescale_i,
  input wire logic [3:0] sel_i,
  output logic tick_o
);
  logic [13:0] mask;

  always_comb begin
    mask = 14'((32'h0000_0001 << sel_i) - 32'h0000_0001);
    if (sel_i == DIV_SEL_RESERVED) begin
      tick_o = 1'b0;
    end else begin
      tick_o = ((prescale_i & mask) == mask);
    end
  end
endmodule

// >>> irrpu_top.sv
`timescale 1ns/1ps
module irrpu_top
  import irrpu_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ir_receive_input_i,
  output logic ir_transmit_output_o,
  output logic irq_o
);
  irrpu_cfg_t cfg_q, cfg_d;
  logic [5:0] car_high_q, car_high_d, car_low_q, car_low_d;
  logic [7:0] len_q, len_d;
  logic tx_level_q, tx_level_d;
  logic counting_q, counting_d;
  irrpu_evt_t flag_q, flag_d, en_q, en_d, evt;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [13:0] pre_q, pre_d;
  logic [5:0] car_cnt_q, car_cnt_d;
  logic car_phase_q, car_phase_d;
  logic sync1_q, sync2_q;
  logic samp_q, samp_d, lvl_q, lvl_d;
  logic out_q, out_d;
  logic cg_tick, lc_tick;
  logic wr, rd_sel, len_wr, lo_en, hi_en;
  logic [1:0] widx;

  irrpu_div_tick u_cg_div (
    .prescale_i(pre_q),
    .sel_i(cfg_q.cg_sel),
    .tick_o(cg_tick)
  );

  irrpu_div_tick u_lc_div (
    .prescale_i(pre_q),
    .sel_i(cfg_q.lc_sel),
    .tick_o(lc_tick)
  );

  // Bus decode; byte lanes 0 and 1 carry the 16-bit registers.
  always_comb begin
    widx = wb_adr_i[3:2];
    wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
    rd_sel = wb_cyc_i && wb_stb_i && !ack_q;
    lo_en = wb_sel_i[0];
    hi_en = wb_sel_i[1];
    len_wr = wr && (widx == ADR_LCNT) && lo_en;
  end

  always_comb begin
    cfg_d = cfg_q;
    car_high_d = car_high_q;
    car_low_d = car_low_q;
    tx_level_d = tx_level_q;
    en_d = en_q;
    ack_d = rd_sel;
    rdat_d = rdat_q;
    if (wr) begin
      unique case (widx)
        ADR_CFG: begin
          if (lo_en) begin
            cfg_d.run = wb_dat_i[CFG_RUN_BIT];
            cfg_d.dir_rx = wb_dat_i[CFG_DIR_BIT];
          end
          if (hi_en) begin
            cfg_d.lc_sel = wb_dat_i[CFG_LCSEL_LSB +: 4];
            cfg_d.cg_sel = wb_dat_i[CFG_CGSEL_LSB +: 4];
          end
        end
        ADR_CAR: begin
          if (lo_en) begin
            car_high_d = wb_dat_i[CAR_HIGH_LSB +: 6];
          end
          if (hi_en) begin
            car_low_d = wb_dat_i[CAR_LOW_LSB +: 6];
          end
        end
        ADR_LCNT: begin
          if (hi_en) begin
            tx_level_d = wb_dat_i[LCNT_LEVEL_BIT];
          end
        end
        ADR_INT: begin
          if (hi_en) begin
            en_d.uf = wb_dat_i[INT_UF_EN_BIT];
            en_d.rise = wb_dat_i[INT_RISE_EN_BIT];
            en_d.fall = wb_dat_i[INT_FALL_EN_BIT];
          end
        end
      endcase
    end
    if (rd_sel) begin
      rdat_d = 32'h0000_0000;
      unique case (widx)
        ADR_CFG: begin
          rdat_d[CFG_RUN_BIT] = cfg_q.run;
          rdat_d[CFG_DIR_BIT] = cfg_q.dir_rx;
          rdat_d[CFG_LCSEL_LSB +: 4] = cfg_q.lc_sel;
          rdat_d[CFG_CGSEL_LSB +: 4] = cfg_q.cg_sel;
        end
        ADR_CAR: begin
          rdat_d[CAR_HIGH_LSB +: 6] = car_high_q;
          rdat_d[CAR_LOW_LSB +: 6] = car_low_q;
        end
        ADR_LCNT: begin
          rdat_d[LCNT_VAL_LSB +: 8] = len_q;
          rdat_d[LCNT_LEVEL_BIT] = cfg_q.dir_rx ? lvl_q : tx_level_q;
        end
        ADR_INT: begin
          rdat_d[INT_UF_FLAG_BIT] = flag_q.uf;
          rdat_d[INT_RISE_FLAG_BIT] = flag_q.rise;
          rdat_d[INT_FALL_FLAG_BIT] = flag_q.fall;
          rdat_d[INT_UF_EN_BIT] = en_q.uf;
          rdat_d[INT_RISE_EN_BIT] = en_q.rise;
          rdat_d[INT_FALL_EN_BIT] = en_q.fall;
        end
      endcase
    end
  end

  // Shared prescaler; it restarts whenever the unit is halted.
  always_comb begin
    pre_d = cfg_q.run ? pre_q + 14'h0_001 : PRESCALE_RESET;
  end

  // Carrier generator.
  always_comb begin
    car_cnt_d = car_cnt_q;
    car_phase_d = car_phase_q;
    if (!cfg_q.run) begin
      car_cnt_d = 6'h0_0;
      car_phase_d = 1'b1;
    end else if (cg_tick) begin
      if (car_cnt_q == (car_phase_q ? car_high_q : car_low_q)) begin
        car_cnt_d = 6'h0_0;
        car_phase_d = !car_phase_q;
      end else begin
        car_cnt_d = car_cnt_q + 6'h0_1;
      end
    end
  end

  // Length counter; a write reloads and restarts it at once.
  always_comb begin
    len_d = len_q;
    counting_d = counting_q;
    evt = '0;
    if (len_wr) begin
      len_d = wb_dat_i[LCNT_VAL_LSB +: 8];
      counting_d = 1'b1;
    end else if (cfg_q.run && counting_q && lc_tick) begin
      if (len_q <= 8'h0_1) begin
        len_d = 8'h0_0;
        counting_d = 1'b0;
        evt.uf = 1'b1;
      end else begin
        len_d = len_q - 8'h0_1;
      end
    end
    // Receive edge filter: a new level must match on two samples.
    samp_d = samp_q;
    lvl_d = lvl_q;
    if (cfg_q.run && cfg_q.dir_rx && cg_tick) begin
      samp_d = sync2_q;
      if (samp_q == sync2_q && sync2_q != lvl_q) begin
        lvl_d = sync2_q;
        evt.rise = sync2_q;
        evt.fall = !sync2_q;
      end
    end
  end

  // Flags: hardware set wins over a write-one clear.
  always_comb begin
    flag_d = flag_q;
    if (wr && widx == ADR_INT && lo_en) begin
      if (wb_dat_i[INT_UF_FLAG_BIT]) flag_d.uf = 1'b0;
      if (wb_dat_i[INT_RISE_FLAG_BIT]) flag_d.rise = 1'b0;
      if (wb_dat_i[INT_FALL_FLAG_BIT]) flag_d.fall = 1'b0;
    end
    flag_d = flag_d | evt;
    out_d = cfg_q.run && !cfg_q.dir_rx && tx_level_q && car_phase_q;
  end

  always_ff @(posedge clk_i) begin
    sync1_q <= ir_receive_input_i;
    sync2_q <= sync1_q;
    if (rst_i) begin
      cfg_q <= '{cg_sel: DIV_SEL_RESET, lc_sel: DIV_SEL_RESET, dir_rx: 1'b0, run: 1'b0};
      car_high_q <= CAR_LEN_RESET;
      car_low_q <= CAR_LEN_RESET;
      len_q <= LEN_RESET;
      tx_level_q <= 1'b0;
      counting_q <= 1'b0;
      flag_q <= '0;
      en_q <= '0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      pre_q <= PRESCALE_RESET;
      car_cnt_q <= 6'h0_0;
      car_phase_q <= 1'b1;
      samp_q <= 1'b0;
      lvl_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      car_high_q <= car_high_d;
      car_low_q <= car_low_d;
      len_q <= len_d;
      tx_level_q <= tx_level_d;
      counting_q <= counting_d;
      flag_q <= flag_d;
      en_q <= en_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      pre_q <= pre_d;
      car_cnt_q <= car_cnt_d;
      car_phase_q <= car_phase_d;
      samp_q <= samp_d;
      lvl_q <= lvl_d;
      out_q <= out_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign ir_transmit_output_o = out_q;
  assign irq_o = |(flag_q & en_q);
endmodule

// >>> irrpu_monitor.sv
`timescale 1ns/1ps
module irrpu_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic ir_transmit_output_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of run, direction and the three enables, updated when a write is taken.
  logic [4:0] sh_q;
  logic [4:0] sh_d;
  logic tk;
  assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
  always_comb begin
    sh_d = sh_q;
    if (tk && wb_adr_i[3:2] == 2'h0 && wb_sel_i[0]) sh_d[1:0] = wb_dat_i[1:0];
    if (tk && wb_adr_i[3:2] == 2'h3 && wb_sel_i[1]) sh_d[4:2] = wb_dat_i[10:8];
  end
  always_ff @(posedge clk_i) sh_q <= rst_i ? 5'h00 : sh_d;
  ack_one_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved");
  tx_mode_a: assert property (
    ir_transmit_output_o |-> $past(sh_q[0]) && !$past(sh_q[1]))
    else $error("output high while halted or receiving");
  irq_en_a: assert property (
    irq_o |-> (sh_q[4:2] | $past(sh_q[4:2])) != 3'h0)
    else $error("interrupt with all enables off");
  rst_idle_a: assert property (
    $fell(rst_i) |-> !wb_ack_o && !irq_o && !ir_transmit_output_o)
    else $error("outputs active after reset");
  cover property (tk && wb_adr_i[3:2] == 2'h0);
  cover property (ir_transmit_output_o);
  cover property ($rose(irq_o));
endmodule

// >>> irrpu_ir_model.sv
`timescale 1ns/1ps
// Receiver module feeding the input pin and LED driver counting lit cycles.
module irrpu_ir_model (
  input wire logic clk_i,
  input wire logic level_i,
  input wire logic led_i,
  output logic rx_o = 1'b0,
  output int lit_o = 0
);
  always @(posedge clk_i) begin
    rx_o <= level_i;
    lit_o <= lit_o + int'(led_i);
  end
endmodule

// >>> irrpu_top_test.sv
`timescale 1ns/1ps
module irrpu_top_test import irrpu_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic lvl = 1'b0;
  logic [37:0] req = 38'h00_0000_0000;
  logic [31:0] rdat;
  logic [31:0] rv;
  logic ack;
  logic tx;
  logic irq;
  logic rx;
  int lit;
  int err_count = 0;
  int n_tests = 0;
  irrpu_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req[37]), .wb_stb_i(req[37]),
    .wb_we_i(req[36]), .wb_adr_i(req[35:32]), .wb_sel_i(4'h3), .wb_dat_i(req[31:0]),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ir_receive_input_i(rx), .ir_transmit_output_o(tx),
    .irq_o(irq));
  irrpu_ir_model pin (.clk_i(clk_i), .level_i(lvl), .led_i(tx), .rx_o(rx), .lit_o(lit));
  initial forever #10 clk_i = ~clk_i;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wb(input logic w, input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_i);
    req <= {1'b1, w, a, 2'b00, 16'h0000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rv = rdat;
    req <= 38'h00_0000_0000;
  endtask
  // The first edge is skipped: the output may still carry the state from before the last write.
  task lit_chk(input int k, input logic [31:0] e);
    int n;
    @(posedge clk_i);
    n = lit;
    repeat (k) @(posedge clk_i);
    chk("led", 32'(lit - n), e);
  endtask
  task t_reset;
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 2'(i), 16'h0000);
      chk("reg", rv, 32'h0000_0000);
    end
    chk("pins", 32'({tx, irq}), 32'h0000_0000);
  endtask
  task t_tx;
    wb(1'b1, ADR_CAR, 16'h0102);
    wb(1'b1, ADR_LCNT, 16'h0000);
    wb(1'b1, ADR_CFG, 16'h1801);
    wb(1'b1, ADR_LCNT, 16'h01ff);
    repeat (20) @(posedge clk_i);
    lit_chk(60, 32'h0000_0024);
    wb(1'b1, ADR_LCNT, 16'h00ff);
    lit_chk(20, 32'h0000_0000);
    wb(1'b1, ADR_LCNT, 16'h01ff);
    wb(1'b1, ADR_CFG, 16'h1803);
    lit_chk(20, 32'h0000_0000);
    wb(1'b1, ADR_CFG, 16'h1800);
    lit_chk(20, 32'h0000_0000);
    wb(1'b1, ADR_LCNT, 16'h0000);
  endtask
  task t_uf;
    wb(1'b1, ADR_INT, 16'h0107);
    wb(1'b1, ADR_CFG, 16'h0f01);
    wb(1'b1, ADR_LCNT, 16'h0001);
    repeat (20) @(posedge clk_i);
    wb(1'b0, ADR_INT, 16'h0000);
    chk("reserved", rv, 32'h0000_0100);
    wb(1'b1, ADR_CFG, 16'h0000);
    wb(1'b1, ADR_CFG, 16'h0201);
    wb(1'b1, ADR_LCNT, 16'h0005);
    repeat (12) @(posedge clk_i);
    wb(1'b1, ADR_LCNT, 16'h0005);
    repeat (12) @(posedge clk_i);
    chk("irq early", 32'(irq), 32'h0000_0000);
    repeat (12) @(posedge clk_i);
    chk("irq", 32'(irq), 32'h0000_0001);
    wb(1'b0, ADR_LCNT, 16'h0000);
    chk("count", 32'(rv[7:0]), 32'h0000_0000);
    wb(1'b0, ADR_INT, 16'h0000);
    chk("int", rv, 32'h0000_0101);
    wb(1'b1, ADR_INT, 16'h0101);
    wb(1'b0, ADR_INT, 16'h0000);
    chk("int clr", 32'({rv[15:0], irq}), 32'h0000_0200);
    wb(1'b1, ADR_CFG, 16'h0000);
  endtask
  task t_rx;
    wb(1'b1, ADR_INT, 16'h0207);
    wb(1'b1, ADR_CFG, 16'h0403);
    lvl <= 1'b1;
    repeat (10) @(posedge clk_i);
    wb(1'b0, ADR_INT, 16'h0000);
    chk("rise", 32'({rv[15:0], irq}), 32'h0000_0405);
    wb(1'b0, ADR_LCNT, 16'h0000);
    chk("level", 32'(rv[8]), 32'h0000_0001);
    lvl <= 1'b0;
    @(posedge clk_i);
    lvl <= 1'b1;
    repeat (10) @(posedge clk_i);
    wb(1'b0, ADR_INT, 16'h0000);
    chk("glitch", rv, 32'h0000_0202);
    wb(1'b1, ADR_INT, 16'h0202);
    lvl <= 1'b0;
    repeat (10) @(posedge clk_i);
    wb(1'b0, ADR_INT, 16'h0000);
    chk("fall", 32'({rv[15:0], irq}), 32'h0000_0408);
    wb(1'b1, ADR_LCNT, 16'h00ff);
    repeat (64) @(posedge clk_i);
    wb(1'b0, ADR_LCNT, 16'h0000);
    chk("live", 32'(rv[7:0] inside {[8'hfa:8'hfc]}), 32'h0000_0001);
    wb(1'b1, ADR_LCNT, 16'h0001);
    repeat (40) @(posedge clk_i);
    wb(1'b0, ADR_INT, 16'h0000);
    chk("rx uf", rv, 32'h0000_0205);
    wb(1'b1, ADR_CFG, 16'h0000);
  endtask
  task end_sim;
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_tx;
    t_uf;
    t_rx;
    end_sim;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    end_sim;
  end
endmodule
bind irrpu_top irrpu_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ir_transmit_output_o(ir_transmit_output_o), .irq_o(irq_o));
